// ### hw/csrb_ram_block.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Shapes 256x16, 512x8, 1024x4 or 2048x2 share one 4096-bit array.
// - Single-port mode shares the write address; dual-port has separate sections.
// - Write and read sections advance at independent rates in dual-port mode.
// - Read and write sections each have their own synchronous clock enable.
// - Alternatively one enable drives input registers, another the output register.
// - Every port register clears from local clear, global clear or chip reset; the array does not.
// - The write strobe is made inside, timed by the write or input enable.
// - Each port path may be registered or bypassed independently.
// - Lookup mode: contents loaded at configuration, never written by user.
// - Blocks sit side by side on a shared address for wider words.
// - Depth cascade by block select, with no added latency.
// - One block gives one write and one read; true two-port needs two.
module csrb_ram_block (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                clr_local,
   input  wire logic                clr_global,
   input  wire csrb_pkg::csrb_cfg_t cfg,
   input  wire logic                load_en,
   input  wire logic [7:0]          load_row,
   input  wire logic [15:0]         load_data,
   input  wire logic                blk_sel,
   input  wire logic                wr_ce,
   input  wire logic                rd_ce,
   input  wire logic                in_ce,
   input  wire logic                out_ce,
   input  wire logic [10:0]         wr_addr,
   input  wire logic [15:0]         wr_data,
   input  wire logic                wr_en,
   input  wire logic [10:0]         rd_addr,
   input  wire logic                rd_en,
   output logic      [15:0]         rd_data
);

   // The array itself is never cleared; only the port registers are.
   logic [15:0] mem [csrb_pkg::ROWS];

   logic [15:0] wdata_q, wdata_d;
   logic [10:0] waddr_q, waddr_d;
   logic        we_q, we_d;
   logic [10:0] raddr_q, raddr_d;
   logic        re_q, re_d;
   logic [15:0] dout_q, dout_d;

   logic        clr_any;
   logic        wr_go;
   logic        rin_go;
   logic        out_go;
   logic [15:0] eff_wdata;
   logic [10:0] eff_waddr;
   logic        eff_we;
   logic [10:0] eff_raddr;
   logic        eff_re;
   logic        wr_strobe;
   logic [7:0]  w_row;
   logic [15:0] w_mask;
   logic [15:0] w_bits;
   logic [7:0]  r_row;
   logic [15:0] rd_word;
   logic [15:0] r_raw;

   // All three clear sources merge into one clear of every port register.
   assign clr_any = rst | clr_local | clr_global;

   // Enable routing: either per section, or input versus output registers.
   always_comb begin
      if (cfg.split_io_clk) begin
         wr_go  = in_ce;
         rin_go = in_ce;
         out_go = out_ce;
      end else begin
         wr_go  = wr_ce;
         rin_go = rd_ce;
         out_go = rd_ce;
      end
   end

   // Per-path bypass selection; a bypassed path reads the port directly.
   always_comb begin
      eff_wdata = cfg.reg_wdata ? wdata_q : wr_data;
      eff_waddr = cfg.reg_waddr ? waddr_q : wr_addr;
      eff_we    = cfg.reg_we ? we_q : wr_en;
      eff_re    = cfg.reg_re ? re_q : rd_en;
      if (cfg.dual_port) begin
         eff_raddr = cfg.reg_raddr ? raddr_q : rd_addr;
      end else begin
         eff_raddr = eff_waddr;
      end
   end

   // Internal write strobe: no external write pulse timing is needed.
   // Lookup mode blocks user writes, and a deselected block ignores them.
   assign wr_strobe = eff_we & wr_go & blk_sel & ~cfg.rom_mode & ~clr_any;

   // Write lane decode. Narrow data is replicated and a mask picks the lane.
   always_comb begin
      w_row  = eff_waddr[7:0];
      w_mask = csrb_pkg::MASK_W16;
      w_bits = eff_wdata;
      unique case (cfg.shape)
         csrb_pkg::CSRB_W16: begin
            w_row  = eff_waddr[7:0];
            w_mask = csrb_pkg::MASK_W16;
            w_bits = eff_wdata;
         end
         csrb_pkg::CSRB_W8: begin
            w_row  = eff_waddr[8:1];
            w_mask = csrb_pkg::MASK_W8 << {eff_waddr[0], 3'b000};
            w_bits = {2{eff_wdata[7:0]}};
         end
         csrb_pkg::CSRB_W4: begin
            w_row  = eff_waddr[9:2];
            w_mask = csrb_pkg::MASK_W4 << {eff_waddr[1:0], 2'b00};
            w_bits = {4{eff_wdata[3:0]}};
         end
         csrb_pkg::CSRB_W2: begin
            w_row  = eff_waddr[10:3];
            w_mask = csrb_pkg::MASK_W2 << {eff_waddr[2:0], 1'b0};
            w_bits = {8{eff_wdata[1:0]}};
         end
      endcase
   end

   // Read lane decode from the array as it stands before this edge's write.
   always_comb begin
      r_row   = eff_raddr[7:0];
      r_raw   = mem[eff_raddr[7:0]];
      rd_word = r_raw;
      unique case (cfg.shape)
         csrb_pkg::CSRB_W16: begin
            r_row   = eff_raddr[7:0];
            r_raw   = mem[r_row];
            rd_word = r_raw;
         end
         csrb_pkg::CSRB_W8: begin
            r_row   = eff_raddr[8:1];
            r_raw   = mem[r_row];
            rd_word = (r_raw >> {eff_raddr[0], 3'b000}) & csrb_pkg::MASK_W8;
         end
         csrb_pkg::CSRB_W4: begin
            r_row   = eff_raddr[9:2];
            r_raw   = mem[r_row];
            rd_word = (r_raw >> {eff_raddr[1:0], 2'b00}) & csrb_pkg::MASK_W4;
         end
         csrb_pkg::CSRB_W2: begin
            r_row   = eff_raddr[10:3];
            r_raw   = mem[r_row];
            rd_word = (r_raw >> {eff_raddr[2:0], 1'b0}) & csrb_pkg::MASK_W2;
         end
      endcase
   end

   // Array update. Configuration load takes priority over a user write.
   always_ff @(posedge clk_sys) begin
      if (load_en) begin
         mem[load_row] <= load_data;
      end else if (wr_strobe) begin
         mem[w_row] <= (mem[w_row] & ~w_mask) | (w_bits & w_mask);
      end
   end

   // Next values of the port registers; each section stalls on its enable.
   always_comb begin
      wdata_d = wdata_q;
      waddr_d = waddr_q;
      we_d    = we_q;
      raddr_d = raddr_q;
      re_d    = re_q;
      dout_d  = dout_q;
      if (clr_any) begin
         wdata_d = csrb_pkg::DATA_RST;
         waddr_d = csrb_pkg::ADDR_RST;
         we_d    = 1'b0;
         raddr_d = csrb_pkg::ADDR_RST;
         re_d    = 1'b0;
         dout_d  = csrb_pkg::DATA_RST;
      end else begin
         if (wr_go) begin
            wdata_d = wr_data;
            waddr_d = wr_addr;
            we_d    = wr_en;
         end
         if (rin_go) begin
            raddr_d = rd_addr;
            re_d    = rd_en;
         end
         // The old word is captured even when this edge writes the same row.
         if (out_go && eff_re) begin
            dout_d = rd_word;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      wdata_q <= wdata_d;
      waddr_q <= waddr_d;
      we_q    <= we_d;
      raddr_q <= raddr_d;
      re_q    <= re_d;
      dout_q  <= dout_d;
   end

   // A deselected block drives zero so cascaded outputs may be ORed.
   // Wide words need no logic here: sibling blocks share the address.
   // Unregistered output is combinational by choice, trading timing for latency.
   always_comb begin
      if (!blk_sel) begin
         rd_data = csrb_pkg::DATA_RST;
      end else if (cfg.reg_dout) begin
         rd_data = dout_q;
      end else begin
         rd_data = eff_re ? rd_word : csrb_pkg::DATA_RST;
      end
   end

   // This block has one write and one read path only; a two-port memory pairs two.

   // Checks on the port behaviour.
   clear_regs_a: assert property (@(posedge clk_sys)
      clr_any |=> (dout_q == 16'h0000) && !we_q && !re_q && (wdata_q == 16'h0000))
      else $error("Port registers not cleared.");

   // Only the row that a refused user write aims at is compared, as others may never be set.
   rom_no_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cfg.rom_mode && !load_en && eff_we && wr_go && blk_sel)
      |=> mem[$past(w_row)] == $past(mem[w_row]))
      else $error("Lookup contents changed by a user write.");

   wr_stall_a: assert property (@(posedge clk_sys) disable iff (clr_any)
      !wr_go |=> $stable(wdata_q) && $stable(waddr_q) && $stable(we_q))
      else $error("Write registers moved while stalled.");

   rd_stall_a: assert property (@(posedge clk_sys) disable iff (clr_any)
      !out_go |=> $stable(dout_q))
      else $error("Output register moved while stalled.");

   split_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cfg.split_io_clk && !in_ce) |-> !wr_strobe)
      else $error("Write strobe without input enable in split mode.");

   write_land_a: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_strobe && !load_en && cfg.shape == csrb_pkg::CSRB_W16)
      |=> mem[$past(w_row)] == $past(eff_wdata))
      else $error("Written word not stored.");

   old_word_a: assert property (@(posedge clk_sys) disable iff (clr_any)
      (out_go && eff_re && wr_strobe && (r_row == w_row))
      |=> dout_q == $past(rd_word))
      else $error("Read during write did not return the old word.");

   single_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
      !cfg.dual_port |-> (eff_raddr == eff_waddr))
      else $error("Single-port read address differs from write address.");

   deselect_a: assert property (@(posedge clk_sys) disable iff (rst)
      !blk_sel |-> (rd_data == 16'h0000) && !wr_strobe)
      else $error("Deselected block active.");

   reg_out_lat_a: assert property (@(posedge clk_sys) disable iff (clr_any)
      (cfg.reg_dout && blk_sel && out_go && eff_re) ##1 (cfg.reg_dout && blk_sel)
      |-> rd_data == $past(rd_word))
      else $error("Registered output not one edge behind the array.");

   // Load and unregistered-output checks. The unregistered one is limited to the
   // full-width shape so that it can be held against the raw array row.
   load_land_a: assert property (@(posedge clk_sys)
      load_en |=> mem[$past(load_row)] == $past(load_data))
      else $error("Configuration load not stored.");

   unreg_out_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!cfg.reg_dout && blk_sel && eff_re && cfg.shape == csrb_pkg::CSRB_W16)
      |-> rd_data == mem[eff_raddr[7:0]])
      else $error("Unregistered output differs from the array.");

   rd_in_stall_a: assert property (@(posedge clk_sys) disable iff (clr_any)
      !rin_go |=> $stable(raddr_q) && $stable(re_q))
      else $error("Read input registers moved while stalled.");

   in_gate_a: assert property (@(posedge clk_sys) disable iff (clr_any)
      (cfg.split_io_clk && !in_ce) |=> $stable(raddr_q) && $stable(re_q))
      else $error("Read input registers moved without input enable.");

   wr_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (!cfg.split_io_clk && !wr_ce) |-> !wr_strobe)
      else $error("Write strobe without write enable.");

   collide_c: cover property (@(posedge clk_sys) disable iff (rst)
      wr_strobe && eff_re && (r_row == w_row));

   rom_read_c: cover property (@(posedge clk_sys) disable iff (rst)
      cfg.rom_mode && eff_re && blk_sel ##1 cfg.rom_mode);

   split_wr_c: cover property (@(posedge clk_sys) disable iff (rst)
      cfg.split_io_clk && wr_strobe);

   narrow_wr_c: cover property (@(posedge clk_sys) disable iff (rst)
      wr_strobe && cfg.shape == csrb_pkg::CSRB_W2);

   unreg_read_c: cover property (@(posedge clk_sys) disable iff (rst)
      !cfg.reg_dout && eff_re && blk_sel);

endmodule

// ### hw/csrb_pkg.sv
package csrb_pkg;

   // Storage geometry: one row of the array holds the widest word.
   localparam int unsigned ROWS        = 256;
   localparam int unsigned ROW_W       = 16;
   localparam int unsigned ROW_AW      = 8;
   localparam int unsigned ADDR_W      = 11;
   localparam int unsigned TOTAL_BITS  = 4096;

   // Lane masks for each of the four word shapes.
   localparam logic [15:0] MASK_W16    = 16'hFFFF;
   localparam logic [15:0] MASK_W8     = 16'h00FF;
   localparam logic [15:0] MASK_W4     = 16'h000F;
   localparam logic [15:0] MASK_W2     = 16'h0003;

   // Reset value of every data and address register.
   localparam logic [15:0] DATA_RST    = 16'h0000;
   localparam logic [10:0] ADDR_RST    = 11'h000;

   // Word shape: depth by width.
   typedef enum logic [1:0] {
      CSRB_W16 = 2'b00,
      CSRB_W8  = 2'b01,
      CSRB_W4  = 2'b10,
      CSRB_W2  = 2'b11
   } csrb_shape_t;

   // Static configuration of one block.
   typedef struct packed {
      csrb_shape_t shape;
      logic        dual_port;
      logic        rom_mode;
      logic        split_io_clk;
      logic        reg_wdata;
      logic        reg_waddr;
      logic        reg_we;
      logic        reg_raddr;
      logic        reg_re;
      logic        reg_dout;
   } csrb_cfg_t;

endpackage

// ### bench/csrb_user_model.sv
`timescale 1ns/1ps

// User logic on the far side: it drives address, data and enables of both sections.
module csrb_user_model (
   input  wire logic        clk_sys,
   output logic      [10:0] wr_addr,
   output logic      [15:0] wr_data,
   output logic             wr_en,
   output logic      [10:0] rd_addr,
   output logic             rd_en
);
   // Lines start low so nothing is unknown before the first request.
   initial begin
      wr_addr = 11'h000;
      wr_data = 16'h0000;
      wr_en   = 1'b0;
      rd_addr = 11'h000;
      rd_en   = 1'b0;
   end

   // One request held for a full cycle; changing at the falling edge keeps set-up and hold
   // clear of the sampling edge. Idle address and data lines show the inverse and enables go low, so stale values never match.
   task automatic op(input logic w, input logic r, input logic [10:0] wa,
                     input logic [10:0] ra, input logic [15:0] d);
      @(negedge clk_sys);
      wr_en   = w;
      wr_addr = wa;
      wr_data = d;
      rd_en   = r;
      rd_addr = ra;
      @(negedge clk_sys);
      wr_en   = 1'b0;
      rd_en   = 1'b0;
      wr_addr = ~wa;
      wr_data = ~d;
      rd_addr = ~ra;
   endtask
endmodule

// ### bench/csrb_ram_block_tb.sv
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module csrb_ram_block_tb;
   typedef struct packed {
      logic [1:0]  shape;
      logic        w;
      logic [10:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } csrb_row_t;

   logic                clk_sys;
   logic                rst;
   logic                clr_local;
   logic                clr_global;
   logic                load_en;
   logic [7:0]          load_row;
   logic [15:0]         load_data;
   logic                blk_sel;
   logic                wr_ce;
   logic                rd_ce;
   logic                in_ce;
   logic                out_ce;
   csrb_pkg::csrb_cfg_t cfg;
   logic [10:0]         wr_addr;
   logic [15:0]         wr_data;
   logic                wr_en;
   logic [10:0]         rd_addr;
   logic                rd_en;
   logic [15:0]         rd_data;
   int                  err_total = 0;
   int                  n_checks = 0;

   // Narrow rows share storage with wide ones, so later rows read back merged lanes.
   csrb_row_t rows [8] = '{
      '{2'h0, 1'h1, 11'h005, 16'hA5C3, 16'hA5C3}, '{2'h1, 1'h1, 11'h00A, 16'h0011, 16'h0011},
      '{2'h1, 1'h1, 11'h00B, 16'h0077, 16'h0077}, '{2'h0, 1'h0, 11'h005, 16'h0000, 16'h7711},
      '{2'h2, 1'h1, 11'h7FF, 16'h000E, 16'h000E}, '{2'h3, 1'h1, 11'h7FE, 16'h0001, 16'h0001},
      '{2'h2, 1'h0, 11'h7FF, 16'h0000, 16'h000D}, '{2'h3, 1'h1, 11'h000, 16'h0003, 16'h0003}};

   csrb_ram_block csrb_ram_block_inst (
      .clk_sys(clk_sys), .rst(rst), .clr_local(clr_local), .clr_global(clr_global),
      .cfg(cfg), .load_en(load_en), .load_row(load_row), .load_data(load_data),
      .blk_sel(blk_sel), .wr_ce(wr_ce), .rd_ce(rd_ce), .in_ce(in_ce), .out_ce(out_ce),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en), .rd_addr(rd_addr),
      .rd_en(rd_en), .rd_data(rd_data));

   csrb_user_model csrb_user_model_inst (
      .clk_sys(clk_sys), .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_addr(rd_addr), .rd_en(rd_en));

   // Free-running 100 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic rw(input logic w, input logic r, input logic [10:0] wa,
                     input logic [10:0] ra, input logic [15:0] d);
      csrb_user_model_inst.op(w, r, wa, ra, d);
   endtask

   // The run needs about a hundred cycles; far more than that means a hang.
   initial begin
      #100us;
      err_total++;
      $display("watchdog expired");
      print_verdict();
   end

   // Main sequence: table of word shapes first, then the awkward cases by hand.
   initial begin
      rst = 1'b1;
      clr_local = 1'b0;
      clr_global = 1'b0;
      load_en = 1'b0;
      load_row = 8'h00;
      load_data = 16'h0000;
      blk_sel = 1'b1;
      wr_ce = 1'b1;
      rd_ce = 1'b1;
      in_ce = 1'b0;
      out_ce = 1'b0;
      cfg = '{shape: csrb_pkg::CSRB_W16, dual_port: 1'b1, reg_dout: 1'b1, default: 1'b0};
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      `CHK("reset output", 16'h0000, rd_data)
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_sys);
         cfg.shape = csrb_pkg::csrb_shape_t'(rows[i].shape);
         if (rows[i].w) begin
            rw(1'b1, 1'b0, rows[i].a, rows[i].a, rows[i].d);
         end
         rw(1'b0, 1'b1, rows[i].a, rows[i].a, 16'h0000);
         `CHK("table read", rows[i].e, rd_data)
      end
      $display("test table done");
      cfg.shape = csrb_pkg::CSRB_W16;
      rw(1'b1, 1'b0, 11'h010, 11'h010, 16'h1111);
      rw(1'b1, 1'b1, 11'h010, 11'h010, 16'h2222);
      `CHK("read during write", 16'h1111, rd_data)
      rw(1'b0, 1'b1, 11'h010, 11'h010, 16'h0000);
      `CHK("after write", 16'h2222, rd_data)
      @(negedge clk_sys);
      wr_ce = 1'b0;
      rd_ce = 1'b0;
      rw(1'b1, 1'b1, 11'h010, 11'h005, 16'h3333);
      `CHK("read stalled", 16'h2222, rd_data)
      @(negedge clk_sys);
      wr_ce = 1'b1;
      rd_ce = 1'b1;
      rw(1'b0, 1'b1, 11'h010, 11'h010, 16'h0000);
      `CHK("write stalled", 16'h2222, rd_data)
      @(negedge clk_sys);
      cfg.rom_mode = 1'b1;
      load_en = 1'b1;
      load_row = 8'h20;
      load_data = 16'hBEEF;
      @(negedge clk_sys);
      load_en = 1'b0;
      rw(1'b1, 1'b0, 11'h020, 11'h020, 16'h0000);
      rw(1'b0, 1'b1, 11'h020, 11'h020, 16'h0000);
      `CHK("lookup read", 16'hBEEF, rd_data)
      @(negedge clk_sys);
      cfg.rom_mode = 1'b0;
      blk_sel = 1'b0;
      rw(1'b1, 1'b0, 11'h020, 11'h020, 16'h1234);
      `CHK("deselected output", 16'h0000, rd_data)
      @(negedge clk_sys);
      blk_sel = 1'b1;
      rw(1'b0, 1'b1, 11'h020, 11'h020, 16'h0000);
      `CHK("deselected write", 16'hBEEF, rd_data)
      @(negedge clk_sys);
      cfg.dual_port = 1'b0;
      rw(1'b1, 1'b0, 11'h030, 11'h030, 16'h5A5A);
      rw(1'b1, 1'b1, 11'h030, 11'h005, 16'h6B6B);
      `CHK("single port read", 16'h5A5A, rd_data)
      @(negedge clk_sys);
      cfg.dual_port = 1'b1;
      cfg.reg_we = 1'b1;
      cfg.reg_waddr = 1'b1;
      cfg.reg_wdata = 1'b1;
      rw(1'b1, 1'b0, 11'h050, 11'h050, 16'h7E7E);
      @(negedge clk_sys);
      rw(1'b0, 1'b1, 11'h050, 11'h050, 16'h0000);
      `CHK("registered write", 16'h7E7E, rd_data)
      @(negedge clk_sys);
      clr_local = 1'b1;
      @(negedge clk_sys);
      clr_local = 1'b0;
      `CHK("local clear", 16'h0000, rd_data)
      rw(1'b0, 1'b1, 11'h050, 11'h050, 16'h0000);
      `CHK("read after clear", 16'h7E7E, rd_data)
      clr_global = 1'b1;
      @(negedge clk_sys);
      clr_global = 1'b0;
      `CHK("global clear", 16'h0000, rd_data)
      cfg.split_io_clk = 1'b1;
      wr_ce = 1'b0;
      rd_ce = 1'b0;
      in_ce = 1'b1;
      rw(1'b1, 1'b0, 11'h040, 11'h040, 16'hC0DE);
      rw(1'b0, 1'b1, 11'h040, 11'h040, 16'h0000);
      `CHK("output held", 16'h0000, rd_data)
      @(negedge clk_sys);
      out_ce = 1'b1;
      rw(1'b0, 1'b1, 11'h040, 11'h040, 16'h0000);
      `CHK("split read", 16'hC0DE, rd_data)
      // Unregistered output is looked at while the read enable still stands.
      @(negedge clk_sys);
      cfg.split_io_clk = 1'b0;
      cfg.reg_dout = 1'b0;
      wr_ce = 1'b1;
      rd_ce = 1'b1;
      fork
         rw(1'b0, 1'b1, 11'h040, 11'h040, 16'h0000);
         begin
            @(negedge clk_sys);
            #2;
            `CHK("unregistered read", 16'hC0DE, rd_data)
         end
      join
      @(negedge clk_sys);
      `CHK("unregistered idle", 16'h0000, rd_data)
      // Registered read address and enable add one edge of latency.
      cfg.reg_dout = 1'b1;
      cfg.reg_raddr = 1'b1;
      cfg.reg_re = 1'b1;
      rw(1'b0, 1'b1, 11'h050, 11'h050, 16'h0000);
      `CHK("registered read early", 16'hC0DE, rd_data)
      @(negedge clk_sys);
      `CHK("registered read address", 16'h7E7E, rd_data)
      // Chip reset in mid-run clears the port registers but keeps the array.
      rst = 1'b1;
      @(negedge clk_sys);
      rst = 1'b0;
      `CHK("mid-run reset", 16'h0000, rd_data)
      rw(1'b0, 1'b1, 11'h050, 11'h050, 16'h0000);
      @(negedge clk_sys);
      `CHK("array kept", 16'h7E7E, rd_data)
      $display("test hand cases done");
      print_verdict();
   end
endmodule
